// ===== irq_host_model.sv
// Host side of both interrupt lines: bus keepers and an input-role driver
`timescale 1ns/100ps
module irq_host_model (
	// Clock and device drive
	input wire logic ref_clk,
	input wire logic irq_pin_a_o,
	input wire logic irq_pin_a_oe,
	input wire logic irq_pin_b_o,
	input wire logic irq_pin_b_oe,
	// Host drive and line levels
	input wire logic ext_en,
	input wire logic ext_lvl,
	output logic     irq_pin_a_i,
	output logic     irq_pin_b_i
);
	// Keepers hold a floating line at its last level
	logic a_keep_q = 1'b0;
	logic b_keep_q = 1'b0;
	assign irq_pin_a_i = irq_pin_a_oe ? irq_pin_a_o : ext_en ? ext_lvl : a_keep_q;
	assign irq_pin_b_i = irq_pin_b_oe ? irq_pin_b_o : ext_en ? ext_lvl : b_keep_q;
	always @(posedge ref_clk) begin
		a_keep_q <= irq_pin_a_i;
		b_keep_q <= irq_pin_b_i;
	end
endmodule

// ===== irq_pin_params.svh
// Register offsets, field positions, reset values and counts for the interrupt pin logic
`ifndef IRQ_PIN_PARAMS_SVH
`define IRQ_PIN_PARAMS_SVH

`define OFS_EVENT_STATUS       8'h0b
`define OFS_PIN_A_ROUTE_MAP    8'h2a
`define OFS_PIN_B_ROUTE_MAP    8'h2b
`define OFS_BUFFER_MODE_CONFIG 8'h28
`define OFS_BUFFER_LEVEL       8'h29
`define OFS_FILTER_CONFIG      8'h2c
`define OFS_POWER_CONFIG       8'h2d
`define OFS_SENSOR_CHECK       8'h2e
`define OFS_DATA_LO_FIRST      8'h08
`define OFS_DATA_LO_LAST       8'h0a
`define OFS_DATA_HI_FIRST      8'h0e
`define OFS_DATA_HI_LAST       8'h15

`define BIT_NEW_SAMPLE         0
`define BIT_BUF_NONEMPTY       1
`define BIT_BUF_LEVEL          2
`define BIT_BUF_OVERRUN        3
`define BIT_MOTION             4
`define BIT_IDLE_MOTION        5
`define BIT_ROUTE_LOW          7
`define BIT_EXT_CLOCK_SEL      6
`define BIT_EXT_TRIGGER_SEL    3
`define BIT_LEVEL_MSB          3
`define BIT_CHECK_ASSERT       0
`define BUF_MODE_LSB           0
`define BUF_MODE_OFF           2'h0
`define BUF_MODE_OLDEST        2'h1

`define RST_BUFFER_LEVEL       8'h80
`define RST_ZERO_BYTE          8'h00
`define BUF_COUNT_W            10
`define BUF_DEPTH              10'h200

`endif

// ===== irq_pin_pkg.sv
// Types shared by the interrupt pin logic
package irq_pin_pkg;

	// Host register access, one cycle strobes
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic       rd_end;
		logic [7:0] addr;
		logic [7:0] wdata;
	} reg_req_t;

	// Events from the sensing core, each a one-cycle pulse
	typedef struct packed {
		logic motion;
		logic idle_motion;
		logic new_sample;
		logic buf_push;
		logic buf_pop;
	} core_evt_t;

	// Drive and enable of one two-way pin
	typedef struct packed {
		logic o;
		logic oe;
	} pin_drv_t;

	typedef enum logic [1:0] {
		RD_IDLE,
		RD_DATA,
		RD_OTHER
	} rd_state_t;

endpackage

// ===== irq_pin_properties.sv
// Port-level assertions for the interrupt pin logic
`timescale 1ns/100ps
`include "irq_pin_params.svh"
module irq_pin_chk import irq_pin_pkg::*; (
	// Clock, reset, register port and core events
	input wire logic            ref_clk,
	input wire logic            rst_b,
	input irq_pin_pkg::reg_req_t  req,
	input wire logic [7:0]      rdata,
	input irq_pin_pkg::core_evt_t evt,
	// Pins and input roles
	input wire logic            irq_pin_a_i,
	input wire logic            irq_pin_a_oe,
	input wire logic            irq_pin_b_i,
	input wire logic            irq_pin_b_oe,
	input wire logic            ext_clock,
	input wire logic            ext_trigger
);
	logic [7:0] map_a_q, map_b_q;
	logic       clk_sel_q, trg_sel_q;
	logic       st_rd, dt_rd, a_en, b_en, a_src, b_src;
	assign st_rd = req.rd && req.addr == 8'h0b;
	assign dt_rd = req.rd && req.addr inside {[8'h08:8'h0a], [8'h0e:8'h15]};
	assign a_en = map_a_q[6:0] != 7'h00 && !clk_sel_q;
	assign b_en = map_b_q[6:0] != 7'h00 && !trg_sel_q;
	assign a_src = clk_sel_q && irq_pin_a_i;
	assign b_src = trg_sel_q && irq_pin_b_i;
	// Shadow of the settings that steer the pins; writes land next cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			map_a_q <= 8'h00;
			map_b_q <= 8'h00;
			clk_sel_q <= 1'b0;
			trg_sel_q <= 1'b0;
		end else if (req.wr) begin
			if (req.addr == 8'h2a) map_a_q <= req.wdata;
			if (req.addr == 8'h2b) map_b_q <= req.wdata;
			if (req.addr == 8'h2d) clk_sel_q <= req.wdata[6];
			if (req.addr == 8'h2c) trg_sel_q <= req.wdata[3];
		end
	end
	// ----
	// Checks
	// ----
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	stat_clr_a: assert property ((st_rd && !evt.motion && !evt.idle_motion) ##1
		(st_rd && !evt.motion && !evt.idle_motion) |=> rdata[5:4] == 2'h0) else $error("motion kept");
	motion_set_a: assert property (evt.motion ##1 st_rd |=> rdata[4])
		else $error("motion bit missing");
	idle_set_a: assert property (evt.idle_motion ##1 st_rd |=> rdata[5])
		else $error("idle bit missing");
	data_clr_a: assert property ((dt_rd && req.rd_end && !evt.new_sample) ##1
		(st_rd && !evt.new_sample) |=> !rdata[0]) else $error("sample bit kept");
	pin_a_oe_a: assert property ($past(rst_b) |-> irq_pin_a_oe == $past(a_en))
		else $error("pin a enable wrong");
	pin_b_oe_a: assert property ($past(rst_b) |-> irq_pin_b_oe == $past(b_en))
		else $error("pin b enable wrong");
	ext_clock_sel_a: assert property ($past(rst_b) |-> ext_clock == $past(a_src))
		else $error("clock input wrong");
	ext_trg_a: assert property ($past(rst_b) |-> ext_trigger == $past(b_src))
		else $error("trigger input wrong");
	cover property (st_rd ##1 rdata[4]);
	cover property (irq_pin_a_oe && irq_pin_b_oe);
	cover property (ext_clock && ext_trigger);
endmodule
bind sensor_interrupt_pin_logic irq_pin_chk chk (.ref_clk, .rst_b, .req, .rdata, .evt,
	.irq_pin_a_i, .irq_pin_a_oe, .irq_pin_b_i, .irq_pin_b_oe, .ext_clock, .ext_trigger);

// ===== irq_route_pin.sv
// One interrupt output: OR of routed sources, polarity, tristate and alternate input role
`timescale 1ns/100ps
`include "irq_pin_params.svh"

module irq_route_pin (
	// Clock and reset
	input  wire logic                ref_clk,
	input  wire logic                rst_b,
	// Sources and routing
	input  wire logic [7:0]          flags,
	input  wire logic [7:0]          route_map,
	input  wire logic                alt_input,
	// Pin drive
	output irq_pin_pkg::pin_drv_t    drv
);
	import irq_pin_pkg::*;

	typedef struct packed {
		pin_drv_t drv;
	} route_state_t;

	route_state_t s_q;
	route_state_t s_d;
	logic         active;
	logic         routed;

	always_comb begin
		s_d    = s_q;
		routed = |route_map[6:0];
		active = |(flags[6:0] & route_map[6:0]);
		// Pin used as an input is never driven
		s_d.drv.oe = routed && !alt_input;
		s_d.drv.o  = active ^ route_map[`BIT_ROUTE_LOW];
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign drv = s_q.drv;

endmodule

// ===== sensor_interrupt_pin_logic.sv
// Interrupt status flags, register file and pin routing for the motion sensor
// ----------------------------------------------------------------------------
// What this block does
// - Each source routes to pin a, pin b or both via a map per pin.
// - A pin is driven from the OR of all sources routed to it.
// - A pin with nothing routed, and both pins in reset, float.
// - Active pins drive high, or low when the map's bit 7 is set.
// - Reading the status register clears motion and idle flags.
// - Reading sample data registers clears the new-sample flag.
// - Non-empty and level flags clear only when their trigger conditions stop holding.
// - Power config bit 6 turns pin a into a clock input.
// - Filter config bit 3 turns pin b into a sampling trigger input.
// - A pin in its input role never signals interrupts.
// - Status bit 4 flags motion, bit 5 flags inactivity.
// - Status bit 0 is set when new sample data is available.
// - No new-sample set during a data read; deferred to its end.
// - A set new-sample flag clears at read start, stays low throughout.
// - Status bit 2 holds while entry count reaches the level setting.
// - Level setting of zero asserts the level flag while mode bit 3 is clear; it resets to 0x80.
// - Status bit 1 holds while the buffer has at least one entry.
// - Status bit 3 sets on overwrite, or on no room in oldest mode.
// - Overrun clears on a buffer read and while the buffer is off.
// - Buffer mode 0b00 disables the buffer and empties it.
// ----------------------------------------------------------------------------
`timescale 1ns/100ps
`include "irq_pin_params.svh"

module sensor_interrupt_pin_logic (
	// Clock and reset
	input  wire logic                  ref_clk,
	input  wire logic                  rst_b,
	// Register port
	input  irq_pin_pkg::reg_req_t      req,
	output logic [7:0]                 rdata,
	// Sensing core events
	input  irq_pin_pkg::core_evt_t     evt,
	// Interrupt pin a
	input  wire logic                  irq_pin_a_i,
	output logic                       irq_pin_a_o,
	output logic                       irq_pin_a_oe,
	// Interrupt pin b
	input  wire logic                  irq_pin_b_i,
	output logic                       irq_pin_b_o,
	output logic                       irq_pin_b_oe,
	// Alternate input roles, sensor check and buffer count toward the core
	output logic                       ext_clock,
	output logic                       ext_trigger,
	output logic                       check_assert,
	output logic [`BUF_COUNT_W-1:0]    buf_count
);
	import irq_pin_pkg::*;

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [7:0]             status;
		logic [7:0]             pin_a_route_map;
		logic [7:0]             pin_b_route_map;
		logic [7:0]             buffer_mode_config;
		logic [7:0]             buffer_level_setting;
		logic [7:0]             filter_config;
		logic [7:0]             power_config;
		logic [7:0]             sensor_check_control;
		logic [`BUF_COUNT_W-1:0] count;
		logic                   sample_pend;
		rd_state_t              rd_state;
		logic [7:0]             rdata;
		logic                   ext_clock;
		logic                   ext_trigger;
	} core_state_t;

	core_state_t s_q;
	core_state_t s_d;

	pin_drv_t    drv_a;
	pin_drv_t    drv_b;

	logic                   is_data_addr;
	logic                   buf_off;
	logic                   push_ok;
	logic                   pop_ok;
	logic                   lost;
	logic [8:0]             level;
	logic                   in_data_read;

	// ------------------------------------------------------------------------
	// Register, flag and buffer count logic
	// ------------------------------------------------------------------------
	always_comb begin
		s_d = s_q;

		is_data_addr = (req.addr >= `OFS_DATA_LO_FIRST && req.addr <= `OFS_DATA_LO_LAST) ||
			(req.addr >= `OFS_DATA_HI_FIRST && req.addr <= `OFS_DATA_HI_LAST);
		buf_off = s_q.buffer_mode_config[`BUF_MODE_LSB +: 2] == `BUF_MODE_OFF;
		level = {s_q.buffer_mode_config[`BIT_LEVEL_MSB], s_q.buffer_level_setting};
		in_data_read = (s_q.rd_state == RD_DATA);

		// Buffer occupancy
		pop_ok  = evt.buf_pop && (s_q.count != '0);
		push_ok = 1'b0;
		lost    = 1'b0;
		if (evt.buf_push && !buf_off) begin
			if (s_q.count != `BUF_DEPTH || pop_ok) begin
				push_ok = 1'b1;
			end else begin
				// Stream overwrites oldest; oldest-saved drops the new one
				lost = 1'b1;
				push_ok = (s_q.buffer_mode_config[`BUF_MODE_LSB +: 2] != `BUF_MODE_OLDEST);
			end
		end
		if (buf_off) begin
			s_d.count = '0;
		end else if (push_ok && !pop_ok && s_q.count != `BUF_DEPTH) begin
			s_d.count = s_q.count + `BUF_COUNT_W'(1);
		end else if (pop_ok && !push_ok) begin
			s_d.count = s_q.count - `BUF_COUNT_W'(1);
		end

		// Level-following buffer flags
		s_d.status[`BIT_BUF_NONEMPTY] = (s_d.count != '0);
		s_d.status[`BIT_BUF_LEVEL] = ({1'b0, s_d.count[8:0]} >= {1'b0, level}) ||
			s_d.count[9];

		// Overrun: set wins over clear, off clears outright
		if (buf_off) begin
			s_d.status[`BIT_BUF_OVERRUN] = 1'b0;
		end else if (lost) begin
			s_d.status[`BIT_BUF_OVERRUN] = 1'b1;
		end else if (pop_ok) begin
			s_d.status[`BIT_BUF_OVERRUN] = 1'b0;
		end

		// Read sequencing; rd_end marks the end of a multibyte read
		if (req.rd && s_q.rd_state == RD_IDLE) begin
			s_d.rd_state = is_data_addr ? RD_DATA : RD_OTHER;
		end
		if (req.rd_end) begin
			s_d.rd_state = RD_IDLE;
		end

		// Motion and idle: read clears, event in the same cycle wins
		if (req.rd && req.addr == `OFS_EVENT_STATUS) begin
			s_d.status[`BIT_MOTION]      = 1'b0;
			s_d.status[`BIT_IDLE_MOTION] = 1'b0;
		end
		if (evt.motion) begin
			s_d.status[`BIT_MOTION] = 1'b1;
		end
		if (evt.idle_motion) begin
			s_d.status[`BIT_IDLE_MOTION] = 1'b1;
		end

		// New sample: held off during a data read, released at its end
		if (req.rd && is_data_addr) begin
			s_d.status[`BIT_NEW_SAMPLE] = 1'b0;
		end
		if (evt.new_sample) begin
			if (in_data_read || (req.rd && is_data_addr)) begin
				s_d.sample_pend = 1'b1;
			end else begin
				s_d.status[`BIT_NEW_SAMPLE] = 1'b1;
			end
		end
		if (s_q.sample_pend && !in_data_read) begin
			s_d.status[`BIT_NEW_SAMPLE] = 1'b1;
			s_d.sample_pend = 1'b0;
		end

		// Register reads
		s_d.rdata = 8'h00;
		if (req.rd) begin
			case (req.addr)
				`OFS_EVENT_STATUS:       s_d.rdata = s_q.status;
				`OFS_PIN_A_ROUTE_MAP:    s_d.rdata = s_q.pin_a_route_map;
				`OFS_PIN_B_ROUTE_MAP:    s_d.rdata = s_q.pin_b_route_map;
				`OFS_BUFFER_MODE_CONFIG: s_d.rdata = s_q.buffer_mode_config;
				`OFS_BUFFER_LEVEL:       s_d.rdata = s_q.buffer_level_setting;
				`OFS_FILTER_CONFIG:      s_d.rdata = s_q.filter_config;
				`OFS_POWER_CONFIG:       s_d.rdata = s_q.power_config;
				`OFS_SENSOR_CHECK:       s_d.rdata = s_q.sensor_check_control;
				default:                 s_d.rdata = 8'h00;
			endcase
		end

		// Register writes
		if (req.wr) begin
			case (req.addr)
				`OFS_PIN_A_ROUTE_MAP:    s_d.pin_a_route_map = req.wdata;
				`OFS_PIN_B_ROUTE_MAP:    s_d.pin_b_route_map = req.wdata;
				`OFS_BUFFER_MODE_CONFIG: s_d.buffer_mode_config = req.wdata;
				`OFS_BUFFER_LEVEL:       s_d.buffer_level_setting = req.wdata;
				`OFS_FILTER_CONFIG:      s_d.filter_config = req.wdata;
				`OFS_POWER_CONFIG:       s_d.power_config = req.wdata;
				`OFS_SENSOR_CHECK:       s_d.sensor_check_control = req.wdata;
				default:                 ;
			endcase
		end

		// Alternate input roles sample the pins
		s_d.ext_clock = s_q.power_config[`BIT_EXT_CLOCK_SEL] && irq_pin_a_i;
		s_d.ext_trigger = s_q.filter_config[`BIT_EXT_TRIGGER_SEL] && irq_pin_b_i;
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_b) begin
			s_q                      <= '0;
			s_q.rd_state             <= RD_IDLE;
			s_q.buffer_level_setting <= `RST_BUFFER_LEVEL;
		end else begin
			s_q <= s_d;
		end
	end

	// ------------------------------------------------------------------------
	// Pin drivers
	// ------------------------------------------------------------------------
	irq_route_pin u_pin_a (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.flags     (s_q.status),
		.route_map (s_q.pin_a_route_map),
		.alt_input (s_q.power_config[`BIT_EXT_CLOCK_SEL]),
		.drv       (drv_a)
	);

	irq_route_pin u_pin_b (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.flags     (s_q.status),
		.route_map (s_q.pin_b_route_map),
		.alt_input (s_q.filter_config[`BIT_EXT_TRIGGER_SEL]),
		.drv       (drv_b)
	);

	assign irq_pin_a_o  = drv_a.o;
	assign irq_pin_a_oe = drv_a.oe;
	assign irq_pin_b_o  = drv_b.o;
	assign irq_pin_b_oe = drv_b.oe;
	assign rdata        = s_q.rdata;
	assign ext_clock    = s_q.ext_clock;
	assign ext_trigger  = s_q.ext_trigger;
	assign check_assert = s_q.sensor_check_control[`BIT_CHECK_ASSERT];
	assign buf_count    = s_q.count;

endmodule

// ===== tb.sv
// Self-checking bench for the interrupt pin logic
`timescale 1ns/100ps
`include "irq_pin_params.svh"
module tb;
	import irq_pin_pkg::*;
	logic                    ref_clk = 1'b0;
	logic                    rst_b = 1'b0;
	reg_req_t                req = '0;
	core_evt_t               evt = '0;
	logic                    ext_en = 1'b0;
	logic                    ext_lvl = 1'b0;
	logic [7:0]              rdata, v;
	logic                    irq_pin_a_i, irq_pin_a_o, irq_pin_a_oe;
	logic                    irq_pin_b_i, irq_pin_b_o, irq_pin_b_oe;
	logic                    ext_clock, ext_trigger, check_assert;
	logic [`BUF_COUNT_W-1:0] buf_count;
	int                      mismatches = 0;
	int                      tests_run = 0;
	always #20 ref_clk = ~ref_clk;
	sensor_interrupt_pin_logic uut (.ref_clk, .rst_b, .req, .rdata, .evt, .irq_pin_a_i,
		.irq_pin_a_o, .irq_pin_a_oe, .irq_pin_b_i, .irq_pin_b_o, .irq_pin_b_oe,
		.ext_clock, .ext_trigger, .check_assert, .buf_count);
	irq_host_model host (.ref_clk, .irq_pin_a_o, .irq_pin_a_oe, .irq_pin_b_o,
		.irq_pin_b_oe, .ext_en, .ext_lvl, .irq_pin_a_i, .irq_pin_b_i);
	task automatic chk(string n, logic [15:0] seen, logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, exp, seen);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge ref_clk);
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		req.wr = 1'b1;
		req.addr = a;
		req.wdata = d;
		tick(1);
		req.wr = 1'b0;
		tick(1);
	endtask
	// Single-byte read: the transaction ends with its only byte
	task automatic rd(logic [7:0] a);
		req.rd = 1'b1;
		req.rd_end = 1'b1;
		req.addr = a;
		tick(1);
		v = rdata;
		req.rd = 1'b0;
		req.rd_end = 1'b0;
		tick(1);
	endtask
	task automatic pu(logic [4:0] e);
		evt = e;
		tick(1);
		evt = '0;
		tick(1);
	endtask
	// Flags reach the pins two cycles late, so let three pass
	task automatic pn(string n, logic [3:0] e);
		tick(3);
		chk(n, {12'h000, irq_pin_a_oe, irq_pin_a_o, irq_pin_b_oe, irq_pin_b_o}, {12'h000, e});
	endtask
	// ----
	// Scenarios
	// ----
	task automatic t_route;
		pn("float", 4'h0);
		rd(8'h29);
		chk("level", v, 8'h80);
		rd(8'h00);
		chk("unmapped", v, 8'h00);
		wr(8'h2a, 8'h30);
		wr(8'h2b, 8'h90);
		pn("quiet", 4'hb);
		pu(5'h10);
		pn("motion", 4'he);
		req.rd = 1'b1;
		req.addr = 8'h0b;
		tick(1);
		chk("stat1", rdata, 8'h10);
		req.rd_end = 1'b1;
		tick(1);
		chk("stat2", rdata, 8'h00);
		req.rd = 1'b0;
		req.rd_end = 1'b0;
		pn("cleared", 4'hb);
		pu(5'h08);
		pn("idle", 4'hf);
		rd(8'h0b);
		chk("idle bit", v, 8'h20);
		wr(8'h2a, 8'h00);
		wr(8'h2b, 8'h00);
		pn("unrouted", 4'h0);
	endtask
	task automatic t_data;
		wr(8'h2a, 8'h01);
		pu(5'h04);
		pn("ready", 4'hc);
		// Data read left open until the end marker below
		req.rd = 1'b1;
		req.addr = 8'h0e;
		tick(1);
		req.rd = 1'b0;
		tick(1);
		pn("start", 4'h8);
		pu(5'h04);
		pn("held", 4'h8);
		req.rd_end = 1'b1;
		tick(1);
		req.rd_end = 1'b0;
		pn("late", 4'hc);
		req.rd = 1'b1;
		req.rd_end = 1'b1;
		req.addr = 8'h0a;
		tick(1);
		req.addr = 8'h0b;
		tick(1);
		req.rd = 1'b0;
		req.rd_end = 1'b0;
		chk("data clear", rdata, 8'h00);
	endtask
	task automatic t_buf;
		wr(8'h28, 8'h02);
		wr(8'h29, 8'h02);
		wr(8'h2a, 8'h04);
		wr(8'h2b, 8'h02);
		pu(5'h02);
		pn("one", 4'hb);
		pu(5'h02);
		pn("level", 4'hf);
		pu(5'h01);
		pn("popped", 4'hb);
		wr(8'h29, 8'h00);
		pn("zero", 4'hf);
		wr(8'h28, 8'h0a);
		pn("msb", 4'hb);
		wr(8'h2a, 8'h08);
		wr(8'h28, 8'h01);
		repeat (512) pu(5'h02);
		chk("kept", buf_count, 10'h200);
		pn("overrun", 4'hf);
		pu(5'h01);
		pn("read out", 4'hb);
		wr(8'h28, 8'h02);
		repeat (2) pu(5'h02);
		pn("overwrite", 4'hf);
		wr(8'h28, 8'h00);
		pn("off", 4'ha);
		chk("emptied", buf_count, 10'h000);
	endtask
	task automatic t_alt;
		wr(8'h2c, 8'h08);
		wr(8'h2d, 8'h40);
		tick(3);
		chk("inputs", {irq_pin_a_oe, irq_pin_b_oe}, 2'h0);
		ext_en = 1'b1;
		ext_lvl = 1'b1;
		tick(1);
		chk("hi", {ext_clock, ext_trigger}, 2'h3);
		ext_lvl = 1'b0;
		tick(1);
		chk("lo", {ext_clock, ext_trigger}, 2'h0);
		wr(8'h2e, 8'h01);
		chk("check", check_assert, 1'b1);
	endtask
	task automatic results;
		if (mismatches == 0 && tests_run > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		tick(8);
		rst_b = 1'b1;
		t_route;
		t_data;
		t_buf;
		t_alt;
		results;
	end
	// Over eight times the expected run
	initial begin
		#(40 * 10000);
		mismatches++;
		results;
	end
endmodule
